/* hdl/hic_defs.svh */
`ifndef HIC_DEFS_SVH
`define HIC_DEFS_SVH

// ==========================================================
// field positions of the selective clear argument
`define HIC_CLR_POS_BIT   0
`define HIC_CLR_UOUT_BIT  1

// ==========================================================
// argument values and widths
`define HIC_ARG_W         4
`define HIC_ARG_MIN       4'h1
`define HIC_ARG_MAX       4'h3

// ==========================================================
// step timing
`define HIC_PERIOD_W      16
`define HIC_TIMER_RST     16'h0000

// ==========================================================
// reset values of the filtered pins (1 = switch open)
`define HIC_SWITCH_RST    1'b1
`define HIC_STRAP_RST     1'b0
`define HIC_SYNC_RST      3'h7
`define HIC_STRAP_SYNC_RST 3'h0

`endif

/* hdl/hic_pkg.sv */
`include "hic_defs.svh"

package hic_pkg;

	// ==========================================================
	// homing phases
	typedef enum logic [1:0] {
		HIC_IDLE      = 2'b00,
		HIC_SEEK_EOT  = 2'b01,
		HIC_SEEK_HOME = 2'b10
	} hic_phase_type;

	// ==========================================================
	// one command as delivered by the parser
	typedef struct packed {
		logic                   is_home;   // 1 = home search, 0 = selective clear
		logic                   has_dir;   // direction argument present
		logic                   dir_neg;   // 1 = counterclockwise
		logic [`HIC_ARG_W-1:0]  clear_arg; // selective clear argument
	} hic_cmd_type;

	// ==========================================================
	// clear pulses handed to the rest of the controller
	typedef struct packed {
		logic pos;   // position counter
		logic prog;  // program in working memory
		logic uout;  // user outputs
	} hic_clear_type;

	// ==========================================================
	// whole state of the block
	typedef struct packed {
		hic_phase_type              phase;
		logic                       dir;
		logic [`HIC_PERIOD_W-1:0]   timer;
		logic                       step;
		hic_clear_type              clr;
		logic                       done;
		logic [2:0]                 eot_sync;
		logic [2:0]                 home_sync;
		logic [2:0]                 strap_sync;
		logic                       eot_f;
		logic                       home_f;
		logic                       strap_f;
	} hic_regs_type;

endpackage : hic_pkg

/* hdl/hic_homing.sv */
// Behaviour
// - home command takes optional search direction
// - missing direction acts as positive direction
// - step at start-stop speed until end-of-travel low
// - then reverse and step until home low
// - base variant clears position and program
// - extended variant clears position, keeps program
// - automatic home after program recall at power-up
// - power-up direction from receive pin strap
// - home command executes immediately on receipt
// - argument clears position, outputs, or both

`include "hic_defs.svh"

module hic_homing
	import hic_pkg::*;
#(
	parameter bit EXTENDED = 1'b0 // 1 keeps the program after homing
) (
	// clock, reset, enable
	input  wire logic                     core_clk,
	input  wire logic                     reset_n,
	input  wire logic                     clk_en,
	// command from parser
	input  wire logic                     cmd_valid,
	output logic                          cmd_ready,
	input  wire hic_cmd_type              cmd,
	// program recall and speed
	input  wire logic                     recall_done,
	input  wire logic [`HIC_PERIOD_W-1:0] start_stop_period,
	// pins from the machine
	input  wire logic                     eot_pin_n,
	input  wire logic                     home_pin_n,
	input  wire logic                     rxd_pin,
	// motor drive
	output logic                          step_pulse,
	output logic                          step_dir,
	// clear pulses and status
	output hic_clear_type                 clear_pulse,
	output logic                          home_busy,
	output logic                          home_done
);

	hic_regs_type q;
	hic_regs_type d;
	logic         cmd_fire;
	logic         auto_start;
	logic         seeking;

	// reload value of the step timer, zero treated as one cycle
	function automatic logic [`HIC_PERIOD_W-1:0] reload(input logic [`HIC_PERIOD_W-1:0] p);
		reload = (p == `HIC_TIMER_RST) ? `HIC_TIMER_RST : p - 1'b1;
	endfunction

	// argument inside the documented range
	function automatic logic arg_ok(input logic [`HIC_ARG_W-1:0] a);
		arg_ok = (a >= `HIC_ARG_MIN) && (a <= `HIC_ARG_MAX);
	endfunction

	// ==========================================================
	// handshake
	assign auto_start = recall_done && (q.phase == HIC_IDLE);
	assign cmd_ready  = clk_en && (q.phase == HIC_IDLE) && !recall_done; // no take while frozen
	assign cmd_fire   = cmd_valid && cmd_ready;
	assign seeking    = (q.phase == HIC_SEEK_EOT) || (q.phase == HIC_SEEK_HOME);

	// ==========================================================
	// next state
	always_comb begin
		d          = q;
		d.step     = 1'b0;
		d.clr      = '0;
		d.done     = 1'b0;

		// pin filters: first stage feeds only the second
		d.eot_sync   = {q.eot_sync[1:0], eot_pin_n};
		d.home_sync  = {q.home_sync[1:0], home_pin_n};
		d.strap_sync = {q.strap_sync[1:0], rxd_pin};
		if (q.eot_sync[1] == q.eot_sync[2]) begin
			d.eot_f = q.eot_sync[2];
		end
		if (q.home_sync[1] == q.home_sync[2]) begin
			d.home_f = q.home_sync[2];
		end
		if (q.strap_sync[1] == q.strap_sync[2]) begin
			d.strap_f = q.strap_sync[2];
		end

		unique case (q.phase)
			HIC_IDLE: begin
				if (auto_start) begin
					d.phase = HIC_SEEK_EOT;
					d.dir   = q.strap_f;
					d.timer = reload(start_stop_period);
				end else if (cmd_fire && cmd.is_home) begin
					d.phase = HIC_SEEK_EOT;
					d.dir   = cmd.has_dir && cmd.dir_neg;
					d.timer = reload(start_stop_period);
				end else if (cmd_fire && arg_ok(cmd.clear_arg)) begin
					d.clr.pos  = cmd.clear_arg[`HIC_CLR_POS_BIT];
					d.clr.uout = cmd.clear_arg[`HIC_CLR_UOUT_BIT];
				end
				// out-of-range clear arguments fall through untouched
			end
			HIC_SEEK_EOT: begin
				if (!q.eot_f) begin
					d.phase = HIC_SEEK_HOME;
					d.dir   = !q.dir;
					d.timer = reload(start_stop_period);
				end else if (q.timer == `HIC_TIMER_RST) begin
					d.step  = 1'b1;
					d.timer = reload(start_stop_period);
				end else begin
					d.timer = q.timer - 1'b1;
				end
			end
			HIC_SEEK_HOME: begin
				// with the switches tied, home reads low here at once
				if (!q.home_f) begin
					d.phase    = HIC_IDLE;
					d.done     = 1'b1;
					d.clr.pos  = 1'b1;
					d.clr.prog = !EXTENDED;
				end else if (q.timer == `HIC_TIMER_RST) begin
					d.step  = 1'b1;
					d.timer = reload(start_stop_period);
				end else begin
					d.timer = q.timer - 1'b1;
				end
			end
			default: begin
				d.phase = HIC_IDLE;
			end
		endcase
	end

	// ==========================================================
	// state register, frozen while the enable is low
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			q            <= '0;
			q.phase      <= HIC_IDLE;
			q.eot_sync   <= `HIC_SYNC_RST;
			q.home_sync  <= `HIC_SYNC_RST;
			q.strap_sync <= `HIC_STRAP_SYNC_RST;
			q.eot_f      <= `HIC_SWITCH_RST;
			q.home_f     <= `HIC_SWITCH_RST;
			q.strap_f    <= `HIC_STRAP_RST;
		end else if (clk_en) begin
			q <= d;
		end
	end

	// ==========================================================
	// outputs
	assign step_pulse  = q.step;
	assign step_dir    = q.dir;
	assign clear_pulse = q.clr;
	assign home_busy   = seeking;
	assign home_done   = q.done;

	// ==========================================================
	// checks
	home_dir_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		clk_en && cmd_fire && cmd.is_home && cmd.has_dir
		|=> q.dir == $past(cmd.dir_neg)
	) else $error("home direction argument not taken");

	default_dir_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		clk_en && cmd_fire && cmd.is_home && !cmd.has_dir
		|=> q.phase == HIC_SEEK_EOT && !q.dir
	) else $error("home without argument not positive");

	step_rate_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		clk_en && q.phase == HIC_SEEK_EOT && q.eot_f && q.timer == `HIC_TIMER_RST
		|=> step_pulse && q.timer == reload($past(start_stop_period))
	) else $error("step not issued at start-stop period");

	eot_reverse_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		clk_en && q.phase == HIC_SEEK_EOT && !q.eot_f
		|=> q.phase == HIC_SEEK_HOME && q.dir != $past(q.dir) && !step_pulse
	) else $error("no reversal at end of travel");

	base_clear_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		!EXTENDED && clk_en && q.phase == HIC_SEEK_HOME && !q.home_f
		|=> clear_pulse.pos && clear_pulse.prog && home_done && q.phase == HIC_IDLE
	) else $error("homing end did not clear counter and program");

	ext_keep_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		EXTENDED && clk_en && q.phase == HIC_SEEK_HOME && !q.home_f
		|=> clear_pulse.pos && !clear_pulse.prog && home_done
	) else $error("extended homing end cleared program");

	auto_home_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		clk_en && recall_done && q.phase == HIC_IDLE
		|=> home_busy && !$past(cmd_ready)
	) else $error("no automatic home after recall");

	strap_dir_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		clk_en && auto_start
		|=> step_dir == $past(q.strap_f)
	) else $error("power-up direction does not follow strap");

	immediate_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		clk_en && cmd_fire && cmd.is_home
		|=> q.phase == HIC_SEEK_EOT
	) else $error("home not started at once");

	clear_sel_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		clk_en && cmd_fire && !cmd.is_home && arg_ok(cmd.clear_arg)
		|=> clear_pulse.pos == $past(cmd.clear_arg[0]) && clear_pulse.uout == $past(cmd.clear_arg[1])
		&& !clear_pulse.prog
	) else $error("selective clear mismatch");

	clear_ignore_a : assert property (
		@(posedge core_clk) disable iff (!reset_n)
		clk_en && cmd_fire && !cmd.is_home && !arg_ok(cmd.clear_arg)
		|=> clear_pulse == '0 && q.phase == HIC_IDLE
	) else $error("out-of-range clear acted");

endmodule // hic_homing

/* testbench/hic_machine_model.sv */
// ==========================================================
// machine model: counts steps and works the two travel switches
module hic_machine_model #(
	parameter int EOT_STEPS = 10, // steps from start to the end-of-travel switch
	parameter int HOME_BACK = 3   // reverse steps from there to the home switch
) (
	// clock and control from the bench
	input  wire logic core_clk,
	input  wire logic rewind,
	input  wire logic tied,
	// motor drive from the block
	input  wire logic step_pulse,
	input  wire logic step_dir,
	// switch pins, pulled up, low when reached
	output logic      eot_pin_n,
	output logic      home_pin_n,
	// travel seen since the last rewind
	output int        fwd_cnt,
	output int        back_cnt
);
	timeunit 1ns;
	timeprecision 100ps;

	logic fwd_dir;
	logic started;

	// first step fixes the outward direction, later steps count out or back
	always @(posedge core_clk) begin
		if (rewind) begin
			fwd_cnt <= 0;
			back_cnt <= 0;
			started <= 1'b0;
		end else if (step_pulse) begin
			if (!started || step_dir == fwd_dir) begin
				fwd_cnt <= fwd_cnt + 1;
				fwd_dir <= step_dir;
				started <= 1'b1;
			end else begin
				back_cnt <= back_cnt + 1;
			end
		end
	end

	// switches close by position; tied wiring makes home follow end-of-travel
	assign eot_pin_n  = !(fwd_cnt - back_cnt >= EOT_STEPS);
	assign home_pin_n = tied ? eot_pin_n : !(back_cnt >= HOME_BACK);
endmodule // hic_machine_model

/* testbench/hic_homing_tb.sv */
// ==========================================================
// bench for the homing and selective clear block
module hic_homing_tb
	import hic_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int EOT = 10;
	localparam int HB  = 3;

	logic          core_clk = 1'b0;
	logic          reset_n, clk_en, cmd_valid, recall_done, rxd_pin, rewind, tied;
	hic_cmd_type   cmd;
	logic          cmd_ready, step_pulse, step_dir, home_busy, home_done, eot_pin_n, home_pin_n;
	hic_clear_type clear_pulse, ext_clear;
	int            fwd_cnt, back_cnt;
	int            mismatches = 0;
	int            checks = 0;

	hic_homing #(.EXTENDED(1'b0)) u_dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .recall_done(recall_done),
		.start_stop_period(16'h0004), .eot_pin_n(eot_pin_n), .home_pin_n(home_pin_n), .rxd_pin(rxd_pin),
		.step_pulse(step_pulse), .step_dir(step_dir), .clear_pulse(clear_pulse),
		.home_busy(home_busy), .home_done(home_done));

	// extended variant in lockstep, only its clear pulses are watched
	hic_homing #(.EXTENDED(1'b1)) u_dut_ext (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
		.cmd_valid(cmd_valid), .cmd_ready(), .cmd(cmd), .recall_done(recall_done),
		.start_stop_period(16'h0004), .eot_pin_n(eot_pin_n), .home_pin_n(home_pin_n), .rxd_pin(rxd_pin),
		.step_pulse(), .step_dir(), .clear_pulse(ext_clear), .home_busy(), .home_done());

	hic_machine_model #(.EOT_STEPS(EOT), .HOME_BACK(HB)) u_machine (.core_clk(core_clk), .rewind(rewind),
		.tied(tied), .step_pulse(step_pulse), .step_dir(step_dir), .eot_pin_n(eot_pin_n),
		.home_pin_n(home_pin_n), .fwd_cnt(fwd_cnt), .back_cnt(back_cnt));

	// 50 MHz clock
	always #10 core_clk = ~core_clk;

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic finish_test;
		if (mismatches == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	// one homing run, started by command or by program recall
	task automatic run_home(input logic auto, input logic has_dir, input logic neg, input logic tie,
		input logic exp_dir);
		int n;
		n = 0;
		@(posedge core_clk);
		rewind <= 1'b1;
		tied <= tie;
		@(posedge core_clk);
		rewind <= 1'b0;
		check("ready", 8'h01, cmd_ready);
		if (auto)
			recall_done <= 1'b1;
		else begin
			cmd_valid <= 1'b1;
			cmd <= '{1'b1, has_dir, neg, 4'h0};
		end
		@(posedge core_clk);
		recall_done <= 1'b0;
		cmd_valid <= 1'b0;
		#1;
		check("busy", 8'h01, home_busy);
		check("dir", exp_dir, step_dir);
		check("refused", 8'h00, cmd_ready);
		while (home_done !== 1'b1 && n < 2000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check("done", 8'h01, home_done);
		check("clears", 8'h06, clear_pulse);
		check("ext clears", 8'h04, ext_clear);
		check("reversed", !exp_dir, step_dir);
		check("eot reached", 8'h01, fwd_cnt >= EOT);
		check("home reached", !tie, back_cnt >= HB);
	endtask

	// ==========================================================
	// every clear argument back to back
	task automatic clear_sweep;
		logic [3:0] a;
		logic [2:0] e;
		for (int i = 0; i < 17; i++) begin
			@(posedge core_clk);
			cmd_valid <= (i < 16);
			cmd <= '{1'b0, 1'b0, 1'b0, 4'(i)};
			if (i > 0) begin
				a = 4'(i - 1);
				e = (a >= 4'h1 && a <= 4'h3) ? {a[0], 1'b0, a[1]} : 3'h0;
				#1;
				check("clear arg", e, clear_pulse);
			end
		end
	endtask

	// ==========================================================
	// enable low: command refused and nothing moves until it rises
	task automatic freeze_clear;
		@(posedge core_clk);
		clk_en <= 1'b0;
		cmd_valid <= 1'b1;
		cmd <= '{1'b0, 1'b0, 1'b0, 4'h3};
		repeat (3) @(posedge core_clk);
		#1;
		check("frozen ready", 8'h00, cmd_ready);
		check("frozen clear", 8'h00, clear_pulse);
		@(posedge core_clk);
		clk_en <= 1'b1;
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		#1;
		check("thawed clear", 8'h05, clear_pulse);
	endtask

	// ==========================================================
	// reset, then the scenarios
	initial begin
		reset_n = 1'b0;
		clk_en = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		recall_done = 1'b0;
		rxd_pin = 1'b1;
		rewind = 1'b1;
		tied = 1'b0;
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		run_home(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		@(posedge core_clk);
		rxd_pin <= 1'b0;
		repeat (4) @(posedge core_clk);
		run_home(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		run_home(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		run_home(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
		run_home(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
		clear_sweep();
		freeze_clear();
		finish_test();
	end

	// watchdog against a hang
	initial begin
		#1000000;
		mismatches++;
		finish_test();
	end
endmodule // hic_homing_tb
